// File: src/sbra_pkg.sv
// Shared types and constants for the system bus release arbiter.
// Assumes one processor-side clock; the bus clock arrives as a sampled input.
package sbra_pkg;

    // Arbiter ownership states, Gray coded along idle, request, own, release
    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_REQUEST = 2'h1,
        ST_OWN     = 2'h3,
        ST_RELEASE = 2'h2
    } sbra_state_type;

    // Release modes: 1 always, 2 priority or common request, 3 priority only
    typedef enum logic [1:0] {
        MODE_ALWAYS = 2'h1,
        MODE_COMMON = 2'h2,
        MODE_PRIO   = 2'h3
    } sbra_mode_type;

    // Levels of active-low lines
    localparam logic LINE_ACTIVE   = 1'b0;
    localparam logic LINE_INACTIVE = 1'b1;

    // Least reset pulse the surrounding logic must give, in processor clocks
    localparam int RESET_MIN_CYCLES = 16;

    // Clocks after reset until bus levels and bus clock edges can be trusted
    localparam int SETTLE_CYCLES = 4;

    // Reset value of a synchroniser stage
    localparam logic SYNC_RESET_LEVEL = 1'b1;

    // Local processor side, same clock domain as sys_clk
    typedef struct packed {
        logic cycle_req;   // Pulse: a system bus transfer cycle is wanted
        logic cycle_done;  // Pulse: the current transfer cycle has ended
        logic halt;        // Level: processor is in its halt state
        logic lock;        // Level: cycles are locked
    } sbra_cpu_in_type;

    // Shared bus side, asynchronous to sys_clk
    typedef struct packed {
        logic priority_grant_in_n;    // Low: this arbiter has highest priority
        logic shared_request_line_n;  // Low: another master asks for the bus
        logic busy_in_n;              // Low: some master owns the bus
        logic release_mode_select;    // High mode 2, low mode 3
        logic always_release;         // High: mode 1 strap
        logic init_n;                 // Low: initialisation
    } sbra_bus_in_type;

    localparam int BUS_IN_WIDTH = $bits(sbra_bus_in_type);

    // Shared bus side outputs; busy and common request are open-drain
    typedef struct packed {
        logic bus_request_out_n;
        logic priority_pass_out_n;
        logic busy_out_n;
        logic busy_oe_n;
        logic shared_req_out_n;
        logic shared_req_oe_n;
    } sbra_bus_out_type;

    localparam sbra_bus_out_type BUS_OUT_IDLE = '{
        bus_request_out_n   : 1'b1,
        priority_pass_out_n : 1'b1,
        busy_out_n          : 1'b1,
        busy_oe_n           : 1'b1,
        shared_req_out_n    : 1'b1,
        shared_req_oe_n     : 1'b1
    };

    // Release mode from the strap and the select line
    function automatic sbra_mode_type sbra_decode_mode(input logic always_rel,
                                                       input logic select);
        if (always_rel) begin
            return MODE_ALWAYS;
        end
        return select ? MODE_COMMON : MODE_PRIO;
    endfunction

    // States in which this arbiter holds its bus request
    function automatic logic sbra_requesting(input sbra_state_type st);
        return (st != ST_IDLE);
    endfunction

endpackage

// File: src/sbra_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes inputs change slowly against sys_clk; bits are not coherent.
`timescale 1ns/1ps
module sbra_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import sbra_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    // Stage one feeds stage two only
    always_comb begin
        next_stage1 = clk_en ? async_in : stage1;
        next_sync   = clk_en ? stage1 : sync_out;
    end

    // Reset to the inactive level of the active-low lines
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1   <= {WIDTH{SYNC_RESET_LEVEL}};
            sync_out <= {WIDTH{SYNC_RESET_LEVEL}};
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync;
        end
    end
endmodule // sbra_sync

// File: src/sbra_edge.sv
// Edge finder for the bus clock, which is sampled as a plain input.
// Assumes the bus clock is slower than half of sys_clk.
`timescale 1ns/1ps
module sbra_edge (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      fall_pulse,
    output logic      rise_pulse
);
    import sbra_pkg::*;

    logic meta;
    logic level;
    logic last;
    logic next_meta;
    logic next_level;
    logic next_last;
    logic next_fall;
    logic next_rise;

    // Edges are found between the second and third stage only
    always_comb begin
        next_meta  = clk_en ? async_in : meta;
        next_level = clk_en ? meta : level;
        next_last  = clk_en ? level : last;
        next_fall  = clk_en & last & ~level;
        next_rise  = clk_en & ~last & level;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta       <= SYNC_RESET_LEVEL;
            level      <= SYNC_RESET_LEVEL;
            last       <= SYNC_RESET_LEVEL;
            fall_pulse <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            meta       <= next_meta;
            level      <= next_level;
            last       <= next_last;
            fall_pulse <= next_fall;
            rise_pulse <= next_rise;
        end
    end
endmodule // sbra_edge

// File: src/sbra_release_arbiter.sv
// Release control of a multi-master system bus arbiter.
// Assumes the processor side runs on sys_clk, the shared bus on a slower bus
// clock that is sampled here, and that priority resolution lives outside.
//
// Notes on behaviour
// - Mode 1 releases the bus after every completed transfer cycle.
// - Mode 2 holds until priority input rises or common request falls.
// - Mode 3 holds until priority input rises; common request low ignored.
// - While lock is asserted only initialisation or reset hands the bus to another master.
// - Outside mode 1 the bus is also released when the processor halts.
// - Initialisation or reset forces release regardless of mode or inputs.
// - Locked-cycle output follows lock, dropping at transfer end or when no cycle is pending.
// - Initialisation low clears and holds bus request, busy, address enable.
// - Initialisation keeps the pending request; the cycle is retried after.
// - Reset clears request, busy, address enable, locked output and pending request.
// - Reset aborts the current cycle at once and never resumes it.
// - Owner frees busy at transaction end; top requester seizes by driving busy.
// - Address enable drops first, request and busy at next bus clock fall.
`timescale 1ns/1ps
module sbra_release_arbiter (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    input  wire logic                      bus_clk_in,
    input  wire sbra_pkg::sbra_cpu_in_type cpu_in,
    input  wire sbra_pkg::sbra_bus_in_type bus_in,
    output sbra_pkg::sbra_bus_out_type     bus_out,
    output logic                           bus_granted,
    output logic                           local_addr_drive_en_n,
    output logic                           locked_cycle_out,
    output sbra_pkg::sbra_mode_type        active_mode
);
    import sbra_pkg::*;

    // Synchronised shared-bus inputs and bus clock edge
    sbra_bus_in_type bus_s;
    logic            bclk_fall;

    // Local cycle tracking
    logic pending;
    logic next_pending;
    logic next_locked;

    // Ownership state and its decisions
    sbra_state_type  state;
    sbra_state_type  next_state;
    sbra_mode_type   mode;
    sbra_mode_type   next_mode;
    logic            init_active;
    logic            boundary;
    logic            lock_hold;
    logic            prio_lost;
    logic            common_asked;
    logic            want_release;
    logic            may_seize;

    // Registered output values
    sbra_bus_out_type next_bus_out;
    logic             next_granted;
    logic             next_aen_n;

    // Warm-up after reset: the synchronisers and the edge finder still hold
    // reset levels for a few clocks, and a false bus clock edge would
    // otherwise time a request off the shared bus clock
    logic [SETTLE_CYCLES-1:0] settle;
    logic [SETTLE_CYCLES-1:0] next_settle;
    logic                     bus_valid;
    logic                     bclk_fall_ok;

    // All shared-bus levels cross through two flip-flops before use
    sbra_sync #(
        .WIDTH (BUS_IN_WIDTH)
    ) u_bus_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (bus_in),
        .sync_out (bus_s)
    );

    // Bus clock is sampled; only its falling edge times shared-bus changes
    sbra_edge u_bclk_edge (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .async_in   (bus_clk_in),
        .fall_pulse (bclk_fall),
        .rise_pulse ()
    );

    // Ones shift in after reset; bus levels are trusted once the second
    // stage holds pin values, bus clock edges one edge-finder pass later
    always_comb begin
        next_settle  = clk_en ? {settle[SETTLE_CYCLES-2:0], 1'b1} : settle;
        bus_valid    = settle[SETTLE_CYCLES-3];
        bclk_fall_ok = bclk_fall & settle[SETTLE_CYCLES-1];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            settle <= '0;
        end else begin
            settle <= next_settle;
        end
    end

    // Decoded conditions shared by the state and output logic
    always_comb begin
        init_active  = (bus_s.init_n == LINE_ACTIVE);
        // Mode holds until the select lines are seen through the synchroniser
        next_mode    = mode;
        if (clk_en && bus_valid) begin
            next_mode = sbra_decode_mode(bus_s.always_release,
                                         bus_s.release_mode_select);
        end
        // A cycle boundary: the cycle ends now or none is in progress
        boundary     = cpu_in.cycle_done | ~pending;
        // Lock is taken as is, it already lives on sys_clk
        lock_hold    = cpu_in.lock | locked_cycle_out;
        prio_lost    = (bus_s.priority_grant_in_n == LINE_INACTIVE);
        common_asked = (bus_s.shared_request_line_n == LINE_ACTIVE);
        // Seize only with top priority and the busy line already freed
        may_seize    = (bus_s.priority_grant_in_n == LINE_ACTIVE) &&
                       (bus_s.busy_in_n == LINE_INACTIVE);
    end

    // Release decision while owning the bus
    always_comb begin
        want_release = 1'b0;
        case (mode)
            MODE_ALWAYS: begin
                want_release = boundary;
            end
            MODE_COMMON: begin
                want_release = boundary & (prio_lost | common_asked);
            end
            MODE_PRIO: begin
                want_release = boundary & prio_lost;
            end
            default: begin
                want_release = boundary;
            end
        endcase
        // Halting frees the bus in the retaining modes as well
        if (boundary && cpu_in.halt) begin
            want_release = 1'b1;
        end
        // Lock overrides every mode; only reset or init can break it
        if (lock_hold) begin
            want_release = 1'b0;
        end
    end

    // Pending local request and the locked-cycle flag
    always_comb begin
        next_pending = pending;
        next_locked  = locked_cycle_out;
        if (clk_en) begin
            // A new request in the same cycle as a completion wins
            if (cpu_in.cycle_done) begin
                next_pending = 1'b0;
            end
            if (cpu_in.cycle_req) begin
                next_pending = 1'b1;
            end
            // Follow lock while set, hold until the transfer ends
            if (cpu_in.lock) begin
                next_locked = 1'b1;
            end else if (boundary) begin
                next_locked = 1'b0;
            end
        end
    end

    // Init does not touch the pending request, so the cycle is retried
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending          <= 1'b0;
            locked_cycle_out <= 1'b0;
        end else begin
            pending          <= next_pending;
            locked_cycle_out <= next_locked;
        end
    end

    // Ownership sequence: request and release are timed on bus clock falls
    always_comb begin
        next_state = state;
        if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    // Requests are timed on a bus clock fall, like the
                    // release of request and busy on the shared bus
                    if (pending && bclk_fall_ok) begin
                        next_state = ST_REQUEST;
                    end
                end
                ST_REQUEST: begin
                    // A cycle that ends before the bus is won needs no bus
                    if (!pending) begin
                        next_state = ST_IDLE;
                    end else if (bclk_fall_ok && may_seize) begin
                        next_state = ST_OWN;
                    end
                end
                ST_OWN: begin
                    if (want_release) begin
                        next_state = ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    // Request and busy are let go on the next bus clock fall
                    if (bclk_fall_ok) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
            // Initialisation forces the bus free whatever else is going on
            if (init_active) begin
                next_state = ST_IDLE;
            end
        end
    end

    // Reset abandons any ownership at once, without waiting for the cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            mode  <= MODE_PRIO;
        end else begin
            state <= next_state;
            mode  <= next_mode;
        end
    end

    // Output values, all taken from the next state so they leave flip-flops
    always_comb begin
        next_bus_out = bus_out;
        next_granted = bus_granted;
        next_aen_n   = local_addr_drive_en_n;
        if (clk_en) begin
            next_bus_out = BUS_OUT_IDLE;
            // One request is held from asking until the bus is let go
            if (sbra_requesting(next_state)) begin
                next_bus_out.bus_request_out_n = LINE_ACTIVE;
            end
            // Busy is pulled while owning and until the next bus clock fall
            if ((next_state == ST_OWN) || (next_state == ST_RELEASE)) begin
                next_bus_out.busy_out_n = LINE_ACTIVE;
                next_bus_out.busy_oe_n  = LINE_ACTIVE;
            end
            // Ask the owner to let go while another master holds the bus
            if ((next_state == ST_REQUEST) &&
                (bus_s.busy_in_n == LINE_ACTIVE)) begin
                next_bus_out.shared_req_out_n = LINE_ACTIVE;
                next_bus_out.shared_req_oe_n  = LINE_ACTIVE;
            end
            // Pass priority down only while neither asking nor owning
            if (!pending && !sbra_requesting(next_state) && !prio_lost) begin
                next_bus_out.priority_pass_out_n = LINE_ACTIVE;
            end
            // Address enable drops as soon as release is decided, ahead of
            // the bus request and busy, which wait for the bus clock
            next_aen_n   = (next_state == ST_OWN) ? LINE_ACTIVE
                                                  : LINE_INACTIVE;
            next_granted = (next_state == ST_OWN);
            // Init holds the driving outputs inactive while it lasts
            if (init_active) begin
                next_bus_out = BUS_OUT_IDLE;
                next_aen_n   = LINE_INACTIVE;
                next_granted = 1'b0;
            end
        end
    end

    // Every output leaves a flip-flop; active_mode mirrors the mode register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_out               <= BUS_OUT_IDLE;
            local_addr_drive_en_n <= LINE_INACTIVE;
            bus_granted           <= 1'b0;
            active_mode           <= MODE_PRIO;
        end else begin
            bus_out               <= next_bus_out;
            local_addr_drive_en_n <= next_aen_n;
            bus_granted           <= next_granted;
            active_mode           <= next_mode;
        end
    end

    // Reset acts even with clk_en low so that a stalled block can still be
    // brought to a known state; the synchronisers are held at reset levels
    // too and settle only in the warm-up after it.

endmodule // sbra_release_arbiter

// File: bench/sbra_chk.sv
// Port checker for the release arbiter, bound beside it.
// Assumes one clock domain on sys_clk and a synchronous reset.
`timescale 1ns/1ps
module sbra_chk (
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       clk_en,
    input wire logic                       bus_clk_in,
    input wire sbra_pkg::sbra_cpu_in_type  cpu_in,
    input wire sbra_pkg::sbra_bus_in_type  bus_in,
    input wire sbra_pkg::sbra_bus_out_type bus_out,
    input wire logic                       bus_granted,
    input wire logic                       local_addr_drive_en_n,
    input wire logic                       locked_cycle_out,
    input wire sbra_pkg::sbra_mode_type    active_mode
);
    import sbra_pkg::*;
    // All checks rest while reset is held
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Reset leaves the bus side idle one edge later
    reset_idle_a: assert property ($fell(rst) |-> bus_out.bus_request_out_n
        && local_addr_drive_en_n && !locked_cycle_out && !bus_granted) else $error("not idle");
    // Initialisation clears request, busy and address enable
    init_idle_a: assert property ((clk_en && !bus_in.init_n)[*5] |->
        bus_out.bus_request_out_n && bus_out.busy_oe_n && local_addr_drive_en_n)
        else $error("init did not clear");
    // Address enable drops first; request and busy wait for the bus clock
    aen_first_a: assert property ($rose(local_addr_drive_en_n) && $past(bus_in.init_n, 2)
        && $past(bus_in.init_n, 3) && $past(bus_in.init_n, 4) |->
        !bus_out.bus_request_out_n && !bus_out.busy_oe_n) else $error("release order");
    // Taking the bus means driving busy low
    seize_busy_a: assert property ($rose(bus_granted) |-> !bus_out.busy_oe_n
        && !bus_out.busy_out_n && !local_addr_drive_en_n) else $error("seize without busy");
    // Locked cycles never give the bus away while initialisation stays high
    lock_holds_a: assert property (clk_en && cpu_in.lock && locked_cycle_out && bus_granted
        && bus_in.init_n && $past(bus_in.init_n) && $past(bus_in.init_n, 2) |=> bus_granted)
        else $error("released while locked");
    // Locked output follows the lock input
    lock_follow_a: assert property (clk_en && cpu_in.lock |=> locked_cycle_out)
        else $error("locked output late");
    lock_drop_a: assert property ($fell(locked_cycle_out) |-> !$past(cpu_in.lock))
        else $error("locked output dropped early");
    // Mode follows the strap and select once they have settled
    mode_map_a: assert property ((clk_en && $stable(bus_in.always_release)
        && $stable(bus_in.release_mode_select))[*5] |-> active_mode == (bus_in.always_release
        ? MODE_ALWAYS : bus_in.release_mode_select ? MODE_COMMON : MODE_PRIO))
        else $error("wrong release mode");
endmodule // sbra_chk

// File: bench/sbra_bus_peer.sv
// Model of the other masters and the wired lines of the shared bus.
// Assumes pull-ups on busy and common request; the bus clock runs free.
`timescale 1ns/1ps
module sbra_bus_peer (
    output logic                           bus_clk,
    input  wire logic                      want,
    input  wire logic                      hi_req,
    input  wire sbra_pkg::sbra_bus_out_type dut_out,
    output logic                           prio_n,
    output logic                           req_n,
    output logic                           busy_n
);
    import sbra_pkg::*;
    logic want_q = 1'h0;
    logic hi_q   = 1'h0;
    // Free-running bus clock, 200 ns period
    initial bus_clk = 1'h0;
    always #100 bus_clk = ~bus_clk;
    // Other masters change their lines only on the bus clock
    always @(posedge bus_clk) begin
        want_q <= want;
        hi_q   <= hi_req;
    end
    // Priority logic goes high while a higher master asks
    assign prio_n = hi_q;
    // Wired lines: any party pulls low; an undriven DUT output counts as released
    assign req_n  = !want_q && !(dut_out.shared_req_oe_n === 1'h0 && !dut_out.shared_req_out_n);
    assign busy_n = !(dut_out.busy_oe_n === 1'h0 && dut_out.busy_out_n === 1'h0);
endmodule // sbra_bus_peer

// File: bench/tb.sv
// Self-checking bench for the system bus release arbiter.
// Assumes the shared bus peer model and the bound port checker.
`timescale 1ns/1ps
module tb;
    import sbra_pkg::*;
    logic             sys_clk = 1'h0;
    logic             rst     = 1'h1;
    logic             want    = 1'h0;
    logic             hi_req  = 1'h0;
    logic             sel     = 1'h0;
    logic             alw     = 1'h0;
    logic             init_n  = 1'h1;
    logic             bus_clk, prio_n, req_n, busy_n, granted, aen_n, locked;
    sbra_cpu_in_type  cpu_in  = '0;
    sbra_bus_in_type  bus_in;
    sbra_bus_out_type bus_out;
    sbra_mode_type    mode;
    int               bad_count = 0;
    int               compares  = 0;
    // Processor clock; bus inputs packed in package field order
    always #12.5 sys_clk = ~sys_clk;
    assign bus_in = {prio_n, req_n, busy_n, sel, alw, init_n};
    sbra_release_arbiter i_dut (.sys_clk, .rst, .clk_en(1'h1), .bus_clk_in(bus_clk),
        .cpu_in, .bus_in, .bus_out, .bus_granted(granted), .local_addr_drive_en_n(aen_n),
        .locked_cycle_out(locked), .active_mode(mode));
    sbra_bus_peer i_peer (.bus_clk, .want, .hi_req, .dut_out(bus_out), .prio_n, .req_n, .busy_n);
    // Inputs move a little after the edge so sampling never races
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Bounded wait on the grant; running out ends the run
    task automatic wait_grant(input logic v);
        for (int i = 0; i < 80 && granted !== v; i++) step(1);
        check("granted", v, granted);
        if (granted !== v) complete_run();
    endtask
    // One-cycle pulse of request (req high) or of cycle end
    task automatic pulse(input logic req);
        cpu_in.cycle_req  = req;
        cpu_in.cycle_done = !req;
        step(1);
        cpu_in.cycle_req  = 1'h0;
        cpu_in.cycle_done = 1'h0;
    endtask
    task automatic acquire();
        pulse(1'h1);
        wait_grant(1'h1);
    endtask
    task automatic set_mode(input logic a, input logic s, input logic [1:0] exp);
        alw = a;
        sel = s;
        step(8);
        check("mode", exp, mode);
    endtask
    // Grant must stay for n cycles; one drop is enough to fail
    task automatic hold_grant(input int n);
        int lost = 0;
        repeat (n) begin
            step(1);
            if (granted !== 1'h1) lost++;
        end
        check("grant held", 2'h1, lost == 0);
    endtask
    task automatic t_mode1();
        set_mode(1'h1, 1'h0, 2'h1);
        acquire();
        pulse(1'h0);
        check("aen", 2'h1, aen_n);
        check("busy kept", 2'h0, bus_out.busy_oe_n);
        check("granted", 2'h0, granted);
        step(12);
        check("busy freed", 2'h1, bus_out.busy_oe_n);
        check("request", 2'h1, bus_out.bus_request_out_n);
        check("prio pass", 2'h0, bus_out.priority_pass_out_n);
        $display("mode 1 test done");
    endtask
    // Common request low mid-cycle must wait for the cycle end
    task automatic t_mode2();
        set_mode(1'h0, 1'h1, 2'h2);
        acquire();
        check("prio kept", 2'h1, bus_out.priority_pass_out_n);
        pulse(1'h0);
        hold_grant(30);
        pulse(1'h1);
        want = 1'h1;
        hold_grant(20);
        pulse(1'h0);
        wait_grant(1'h0);
        want = 1'h0;
        $display("mode 2 test done");
    endtask
    task automatic t_mode3();
        set_mode(1'h0, 1'h0, 2'h3);
        acquire();
        pulse(1'h0);
        want = 1'h1;
        hold_grant(30);
        hi_req = 1'h1;
        wait_grant(1'h0);
        want = 1'h0;
        hi_req = 1'h0;
        $display("mode 3 test done");
    endtask
    // Lock blocks the mode 1 release; the locked output waits for cycle end
    task automatic t_lock();
        set_mode(1'h1, 1'h0, 2'h1);
        cpu_in.lock = 1'h1;
        acquire();
        check("locked", 2'h1, locked);
        pulse(1'h0);
        hold_grant(20);
        pulse(1'h1);
        cpu_in.lock = 1'h0;
        step(3);
        check("locked kept", 2'h1, locked);
        pulse(1'h0);
        wait_grant(1'h0);
        check("locked", 2'h0, locked);
        $display("lock test done");
    endtask
    // Initialisation mid-cycle, then retry without a new request, then halt
    task automatic t_init();
        set_mode(1'h0, 1'h0, 2'h3);
        acquire();
        init_n = 1'h0;
        step(6);
        check("request", 2'h1, bus_out.bus_request_out_n);
        check("aen", 2'h1, aen_n);
        check("busy", 2'h1, bus_out.busy_oe_n);
        check("granted", 2'h0, granted);
        init_n = 1'h1;
        wait_grant(1'h1);
        pulse(1'h0);
        cpu_in.halt = 1'h1;
        wait_grant(1'h0);
        cpu_in.halt = 1'h0;
        $display("init test done");
    endtask
    // Reset aborts a locked cycle at once and drops the pending request
    task automatic t_abort();
        cpu_in.lock = 1'h1;
        acquire();
        rst = 1'h1;
        step(1);
        check("granted", 2'h0, granted);
        check("locked", 2'h0, locked);
        check("request", 2'h1, bus_out.bus_request_out_n);
        step(15);
        rst = 1'h0;
        cpu_in.lock = 1'h0;
        step(40);
        check("not resumed", 2'h1, bus_out.bus_request_out_n);
        check("granted", 2'h0, granted);
        $display("reset abort test done");
    endtask
    // Main sequence: reset, then every scenario in turn
    initial begin
        step(16);
        check("request", 2'h1, bus_out.bus_request_out_n);
        check("mode", 2'h3, mode);
        rst = 1'h0;
        $display("reset test done");
        t_mode1();
        t_mode2();
        t_mode3();
        t_lock();
        t_init();
        t_abort();
        complete_run();
    end
endmodule // tb
bind sbra_release_arbiter sbra_chk i_chk (.sys_clk, .rst, .clk_en, .bus_clk_in, .cpu_in,
    .bus_in, .bus_out, .bus_granted, .local_addr_drive_en_n, .locked_cycle_out, .active_mode);
